// [scu_store_cond.sv]
// store-conditional execution unit with apb configuration registers
// Operation
// R1: user-word form adds sign-extended 9-bit offset to base register
// R2: intact sequence writes memory first, then returns 1 in source register
// R3: broken sequence leaves memory alone and returns 0
// R4: user-word form with nonzero low two address bits raises address error
// R5: coherent store by another agent to linked block makes it fail
// R6: exception return between link and store makes it fail
// R7: exception taken between link and store makes it fail
// R8: local access or wide code region may succeed or fail freely
// R9: software pairs each store with a load-linked to same address
// R10: software keeps one consistent cached access type per location
// R11: user-word form translates through user mapping in mixed segments
// R12: user-word form exists only when extended addressing is enabled
// R13: uncached sequences need the uncached-link enable, else they fail
// R14: paired data is high word above source word
// R15: paired form has no offset and must be double-word aligned
// R16: paired write is two word writes held atomic together
// R17: paired form fails on link address mismatch or clear link
// R18: paired success depends on link flag and address only
// R19: own loads to the linked block never break the sequence
// R20: paired form exists only when paired-absent bit is zero
// R21: paired encoding has subcode 1001 and high register in bits 8..4
// R22: user-word form reports tlb, address, watch, ri, cpu faults
// R23: uncached store never succeeds locally, monitor decides
// R24: own uncached store to linked address breaks the sequence; the code does this only when the link itself was set uncached
// R25: every completed store clears the link flag
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`include "scu_cfg.svh"
module scu_store_cond (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic issueValid,
    input wire logic [31:0] instr,
    input wire logic [31:0] baseVal,
    input wire logic [31:0] srcVal,
    input wire logic [31:0] hiVal,
    input wire logic cpuUsable,
    output logic issueReady,
    output logic xlReq,
    output logic [31:0] xlVaddr,
    output logic xlUserMap,
    input wire logic xlAck,
    input wire logic [31:0] xlPaddr,
    input wire logic xlUncached,
    input wire scu_pkg::scu_exc_t xlExc,
    output scu_pkg::scu_wr_t memWr,
    input wire logic memAck,
    output scu_pkg::scu_mon_t monReq,
    input wire logic monAck,
    input wire logic monPass,
    input wire logic llSet,
    input wire logic [31:0] link_address,
    input wire logic llUncached,
    input wire logic snoopStore,
    input wire logic [31:0] snoopAddr,
    input wire logic eretExec,
    input wire logic excTaken,
    input wire logic ucStore,
    input wire logic [31:0] ucAddr,
    output logic linkValid,
    output scu_pkg::scu_rslt_t result
);
    scu_pkg::scu_state_t state_r;
    scu_pkg::scu_dec_t dec;
    logic [2:0] cfg_r;
    logic opPaired_r;
    logic [4:0] srcIdx_r;
    logic [31:0] loWord_r;
    logic [31:0] hiWord_r;
    logic [31:0] paddr_r;
    logic [31:0] linkAddr;
    logic linkUncached;

    scu_decode u_dec (
        .instr(instr),
        .dec(dec)
    );

    // configuration bits
    wire extVaEn = cfg_r[`SCU_CFG_EXTVA];
    wire ucLinkEn = cfg_r[`SCU_CFG_UCLINK];
    wire pairAbsent = cfg_r[`SCU_CFG_PAIRABS];

    // issue-time checks
    wire accept = issueValid && issueReady;
    wire [31:0] eaUser = {{23{dec.offset[8]}}, dec.offset} + baseVal; // R1
    wire [31:0] ea = dec.isPaired ? baseVal : eaUser; // R15
    wire misal = dec.isPaired ? (ea[2:0] != 3'h0) : (ea[1:0] != 2'h0);
    wire legal = (dec.isUser && extVaEn) // R12
        || (dec.isPaired && !pairAbsent); // R20
    wire scu_pkg::scu_exc_t issueExc = !legal ? scu_pkg::EXC_RI
        : (dec.isUser && !cpuUsable) ? scu_pkg::EXC_CPU // R22
        : misal ? scu_pkg::EXC_ADDR // R4 R15
        : scu_pkg::EXC_NONE;

    // decision once the address is translated
    wire inXlate = state_r == scu_pkg::ST_XLATE;
    wire xlDone = inXlate && xlAck;
    wire addrOk = !opPaired_r
        || xlPaddr[31:3] == linkAddr[31:3]; // R17 R18
    wire ucBad = xlUncached && !ucLinkEn; // R13
    wire linkOk = linkValid && addrOk && !ucBad; // R3 R19
    wire goMon = linkOk && xlUncached; // R23
    wire goWr = linkOk && !xlUncached;
    wire xlFault = xlExc != scu_pkg::EXC_NONE; // R22

    // completion of one store-conditional
    wire finIssue = accept && issueExc != scu_pkg::EXC_NONE;
    wire finXl = xlDone && (xlFault || !(goWr || goMon));
    wire inLo = state_r == scu_pkg::ST_WR_LO;
    wire inHi = state_r == scu_pkg::ST_WR_HI;
    wire inMon = state_r == scu_pkg::ST_MON;
    wire finWr = memAck && ((inLo && !opPaired_r) || inHi);
    wire finMon = inMon && monAck;
    wire finish = finIssue || finXl || finWr || finMon;
    wire finOk = finWr || (finMon && monPass); // R2 R23
    wire scu_pkg::scu_exc_t finExc = finIssue ? issueExc
        : (finXl && xlFault) ? xlExc : scu_pkg::EXC_NONE;

    scu_link u_link (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .llSet(llSet),
        .link_address(link_address),
        .llUncached(llUncached),
        .scClear(finish),
        .snoopStore(snoopStore),
        .snoopAddr(snoopAddr),
        .eretExec(eretExec),
        .excTaken(excTaken),
        .ucStore(ucStore),
        .ucAddr(ucAddr),
        .linkValid_r(linkValid),
        .linkAddr_r(linkAddr),
        .linkUncached_r(linkUncached)
    );

    // sequencer
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= scu_pkg::ST_IDLE;
        end else begin
            case (state_r)
                scu_pkg::ST_IDLE: begin
                    if (accept && !finIssue) begin
                        state_r <= scu_pkg::ST_XLATE;
                    end
                end
                scu_pkg::ST_XLATE: begin
                    if (xlDone && !finXl) begin
                        state_r <= goWr ? scu_pkg::ST_WR_LO
                            : scu_pkg::ST_MON;
                    end else if (finXl) begin
                        state_r <= scu_pkg::ST_IDLE;
                    end
                end
                scu_pkg::ST_WR_LO: begin
                    if (memAck) begin
                        state_r <= opPaired_r ? scu_pkg::ST_WR_HI
                            : scu_pkg::ST_IDLE; // R16
                    end
                end
                scu_pkg::ST_WR_HI, scu_pkg::ST_MON: begin
                    if (finish) begin
                        state_r <= scu_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_r <= scu_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // operands caught at issue and translation
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            opPaired_r <= 1'b0;
            srcIdx_r <= 5'h0;
            loWord_r <= 32'h0;
            hiWord_r <= 32'h0;
            paddr_r <= 32'h0;
        end else begin
            if (accept) begin
                opPaired_r <= dec.isPaired;
                srcIdx_r <= dec.srcIdx;
                loWord_r <= srcVal; // R14
                hiWord_r <= hiVal; // R14
            end
            if (xlDone) begin
                paddr_r <= xlPaddr;
            end
        end
    end

    // translation request, user mapping for the user-word form
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            xlReq <= 1'b0;
            xlVaddr <= 32'h0;
            xlUserMap <= 1'b0;
            issueReady <= 1'b0;
        end else begin
            issueReady <= (state_r == scu_pkg::ST_IDLE && !accept) || finish;
            if (accept && !finIssue) begin
                xlReq <= 1'b1;
                xlVaddr <= ea;
                xlUserMap <= dec.isUser; // R11
            end else if (xlDone) begin
                xlReq <= 1'b0;
            end
        end
    end

    // memory writes, low word first, lock held across the pair
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            memWr <= '0;
        end else if (xlDone && goWr && !xlFault) begin
            memWr <= {1'b1, xlPaddr, loWord_r, opPaired_r}; // R2 R16
        end else if (inLo && memAck && opPaired_r) begin
            memWr <= {1'b1, paddr_r + `SCU_PAIR_STEP, hiWord_r, 1'b0};
        end else if (memAck) begin
            memWr.valid <= 1'b0;
        end
    end

    // uncached stores go to the external monitor
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            monReq <= '0;
        end else if (xlDone && goMon && !xlFault) begin
            monReq <= {1'b1, xlPaddr, hiWord_r, loWord_r, opPaired_r}; // R23
        end else if (monAck) begin
            monReq.valid <= 1'b0;
        end
    end

    // writeback of the outcome, success bit in bit zero
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            result <= '0;
        end else begin
            result.valid <= finish;
            result.we <= finExc == scu_pkg::EXC_NONE;
            result.idx <= finIssue ? dec.srcIdx : srcIdx_r;
            result.data <= {31'h0, finOk}; // R2 R3
            result.exc <= finExc;
        end
    end

    // apb slave, zero wait states
    wire apbSetup = psel && !penable;
    wire apbWr = psel && penable && pready && pwrite;
    wire hitCfg = paddr == `SCU_OFF_CFG;
    wire hitStat = paddr == `SCU_OFF_STAT;
    wire hitLaddr = paddr == `SCU_OFF_LADDR;
    wire unmapped = !(hitCfg || hitStat || hitLaddr);
    wire busy = state_r != scu_pkg::ST_IDLE;
    wire [31:0] rdMux = hitCfg ? {29'h0, cfg_r}
        : hitStat ? {29'h0, busy, linkUncached, linkValid}
        : hitLaddr ? linkAddr : 32'h0;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= apbSetup;
            pslverr <= apbSetup && unmapped;
            prdata <= apbSetup ? rdMux : 32'h0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r <= `SCU_CFG_RST;
        end else if (apbWr && hitCfg) begin
            cfg_r <= pwdata[2:0];
        end
    end

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_pairLo;
        inLo && opPaired_r && memAck;
    endsequence
    sequence s_failDecide;
        xlDone && !xlFault && !(goWr || goMon);
    endsequence

    a_pair_atomic: assert property (s_pairLo |=> inHi && memWr.valid // R16
        && !memWr.lock && memWr.addr == paddr_r + `SCU_PAIR_STEP)
        else $error("paired second write missing");
    a_pair_data: assert property (s_pairLo |-> // R14
        memWr.data == loWord_r ##1 memWr.data == hiWord_r)
        else $error("paired word order wrong");
    a_fail_quiet: assert property (s_failDecide |=> result.valid // R3
        && result.we && result.data == 32'h0 && !memWr.valid
        && !monReq.valid)
        else $error("failed store touched memory");
    a_succ_one: assert property (inHi && memAck |=> // R2
        result.valid && result.we && result.data == 32'h1)
        else $error("success not reported");
    a_word_align: assert property (accept && dec.isUser && extVaEn // R4
        && cpuUsable && ea[1:0] != 2'h0 |=> result.valid
        && !result.we && result.exc == scu_pkg::EXC_ADDR)
        else $error("misaligned word not faulted");
    a_pair_align: assert property (accept && dec.isPaired // R15
        && !pairAbsent && ea[2:0] != 3'h0 |=>
        result.exc == scu_pkg::EXC_ADDR && !xlReq)
        else $error("misaligned pair not faulted");
    a_user_absent: assert property (accept && dec.isUser // R12
        && !extVaEn |=> result.exc == scu_pkg::EXC_RI)
        else $error("user word form not refused");
    a_pair_absent: assert property (accept && dec.isPaired // R20
        && pairAbsent |=> result.exc == scu_pkg::EXC_RI)
        else $error("paired form not refused");
    a_link_clear: assert property (result.valid // R25
        && !$past(llSet) |-> !linkValid)
        else $error("link survived store");
    a_exception_return_kill: assert property (eretExec && !llSet |=> !linkValid) // R6
        else $error("link survived exception return");
    a_uc_forward: assert property (xlDone && !xlFault && goMon // R23
        |=> monReq.valid && !memWr.valid ##1 !result.valid || monAck)
        else $error("uncached store not forwarded");
endmodule

// [scu_cfg.svh]
// offsets, field positions and encodings for the store-conditional unit
`ifndef SCU_CFG_SVH
`define SCU_CFG_SVH
`define SCU_MAJOR 6'h18
`define SCU_SUB_PAIR 4'h9
`define SCU_SUB_USER 4'hA
`define SCU_FN_USER 3'h6
`define SCU_BLK_LSB 5
`define SCU_OFF_CFG 12'h000
`define SCU_OFF_STAT 12'h004
`define SCU_OFF_LADDR 12'h008
`define SCU_CFG_EXTVA 0
`define SCU_CFG_UCLINK 1
`define SCU_CFG_PAIRABS 2
`define SCU_CFG_RST 3'h1
`define SCU_PAIR_STEP 32'h0000_0004
`endif

// [scu_pkg.sv]
// types shared by the store-conditional unit
package scu_pkg;
    typedef enum logic [2:0] {
        EXC_NONE, EXC_ADDR, EXC_RI, EXC_CPU,
        EXC_TLB_REFILL, EXC_TLB_INVALID, EXC_TLB_MOD, EXC_WATCH
    } scu_exc_t;
    typedef enum {ST_IDLE, ST_XLATE, ST_WR_LO, ST_WR_HI, ST_MON} scu_state_t;
    typedef struct packed {
        logic isUser;
        logic isPaired;
        logic [4:0] srcIdx;
        logic [4:0] baseIdx;
        logic [4:0] hiIdx;
        logic [8:0] offset;
    } scu_dec_t;
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic [31:0] data;
        logic lock;
    } scu_wr_t;
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic [63:0] data;
        logic paired;
    } scu_mon_t;
    typedef struct packed {
        logic valid;
        logic we;
        logic [4:0] idx;
        logic [31:0] data;
        scu_exc_t exc;
    } scu_rslt_t;
endpackage

// [scu_decode.sv]
// instruction field decoder for both store-conditional forms
`timescale 1ns/10ps
`include "scu_cfg.svh"
module scu_decode (
    input wire logic [31:0] instr,
    output scu_pkg::scu_dec_t dec
);
    wire major = instr[31:26] == `SCU_MAJOR;
    assign dec.isPaired = major && instr[15:12] == `SCU_SUB_PAIR
        && instr[11:9] == 3'h0 && instr[3:0] == 4'h0; // R21
    assign dec.isUser = major && instr[15:12] == `SCU_SUB_USER
        && instr[11:9] == `SCU_FN_USER;
    assign dec.srcIdx = instr[25:21];
    assign dec.baseIdx = instr[20:16];
    assign dec.hiIdx = instr[8:4]; // R21
    assign dec.offset = instr[8:0];
endmodule

// [scu_link.sv]
// link flag and linked address tracker
`timescale 1ns/10ps
`include "scu_cfg.svh"
module scu_link (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic llSet,
    input wire logic [31:0] link_address,
    input wire logic llUncached,
    input wire logic scClear,
    input wire logic snoopStore,
    input wire logic [31:0] snoopAddr,
    input wire logic eretExec,
    input wire logic excTaken,
    input wire logic ucStore,
    input wire logic [31:0] ucAddr,
    output logic linkValid_r,
    output logic [31:0] linkAddr_r,
    output logic linkUncached_r
);
    wire blkHit = snoopAddr[31:`SCU_BLK_LSB] == linkAddr_r[31:`SCU_BLK_LSB];
    wire ucHit = linkUncached_r && ucAddr[31:2] == linkAddr_r[31:2];
    // loads never kill the link, only these events do // R8 R19
    wire killLink = scClear // R25
        || (snoopStore && blkHit) // R5
        || eretExec // R6
        || excTaken // R7
        || (ucStore && ucHit); // R24

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            linkValid_r <= 1'b0;
            linkAddr_r <= 32'h0;
            linkUncached_r <= 1'b0;
        end else if (llSet) begin
            linkValid_r <= 1'b1;
            linkAddr_r <= link_address;
            linkUncached_r <= llUncached;
        end else if (killLink) begin
            linkValid_r <= 1'b0;
        end
    end
endmodule

// [scu_far_model.sv]
// far side model: translator, memory port and uncached monitor
`timescale 1ns/10ps
module scu_far_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic slow,
    input wire logic uncIn,
    input wire scu_pkg::scu_exc_t excIn,
    input wire logic passIn,
    input wire logic xlReq,
    input wire logic [31:0] xlVaddr,
    output logic xlAck,
    output logic [31:0] xlPaddr,
    output logic xlUncached,
    output scu_pkg::scu_exc_t xlExc,
    input wire scu_pkg::scu_wr_t memWr,
    output logic memAck,
    input wire scu_pkg::scu_mon_t monReq,
    output logic monAck,
    output logic monPass
);
    logic [1:0] waitCnt_r;
    logic pend;
    scu_pkg::scu_wr_t wq[$];
    assign pend = (xlReq & ~xlAck) | (memWr.valid & ~memAck)
        | (monReq.valid & ~monAck);
    // identity mapping; answer lines scrambled outside the ack cycle
    assign xlPaddr = xlAck ? xlVaddr : ~xlVaddr;
    assign xlUncached = xlAck ? uncIn : ~uncIn;
    assign xlExc = xlAck ? excIn : scu_pkg::scu_exc_t'(~excIn);
    assign monPass = monAck ? passIn : ~passIn;
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            xlAck <= 1'b0;
            memAck <= 1'b0;
            monAck <= 1'b0;
            waitCnt_r <= 2'h0;
        end else begin
            xlAck <= 1'b0;
            memAck <= 1'b0;
            monAck <= 1'b0;
            if (memWr.valid && memAck) wq.push_back(memWr);
            if (pend && waitCnt_r != 2'h0) waitCnt_r <= waitCnt_r - 2'h1;
            if (pend && waitCnt_r == 2'h0) begin
                waitCnt_r <= slow ? 2'h3 : 2'h0;
                xlAck <= xlReq & ~xlAck;
                memAck <= memWr.valid & ~memAck;
                monAck <= monReq.valid & ~monAck;
            end
        end
    end
endmodule

// [test_store_conditional_unit.sv]
// self-checking bench for the store-conditional unit
`timescale 1ns/10ps
`include "scu_cfg.svh"
module test_store_conditional_unit;
    logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, instr, baseVal, srcVal, hiVal;
    logic issueValid, cpuUsable, issueReady, xlReq, xlUserMap, xlAck;
    logic [31:0] xlVaddr, xlPaddr, link_address, snoopAddr, ucAddr;
    logic xlUncached, memAck, monAck, monPass, llSet, llUncached;
    logic snoopStore, eretExec, excTaken, ucStore, linkValid;
    logic slow, uncIn, passIn, umSeen, monSeen, lvSeen, er, ok, pa;
    scu_pkg::scu_exc_t xlExc, excIn;
    scu_pkg::scu_wr_t memWr;
    scu_pkg::scu_mon_t monReq, mr;
    scu_pkg::scu_rslt_t result, rs;
    logic [31:0] lfsr = 32'h44A95A1E;
    logic [31:0] va, vaSeen, rd, d1, s, h, ins;
    logic [8:0] o;
    int n_fail, check_count, n0, k;
    scu_store_cond DUT (.*);
    scu_far_model FAR (.*);
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    function automatic logic [31:0] encU(input logic [4:0] a, b,
        input logic [8:0] f);
        return {`SCU_MAJOR, a, b, `SCU_SUB_USER, `SCU_FN_USER, f};
    endfunction
    function automatic logic [31:0] encP(input logic [4:0] a, b, c);
        return {`SCU_MAJOR, a, b, `SCU_SUB_PAIR, 3'h0, c, 4'h0};
    endfunction
    task automatic chk(input logic [95:0] got, exp, input string m);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %0h exp %0h",
                $time, m, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            n_fail++;
            $display("unexpected at %0t: bus answer missing", $time);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic ll(input logic [31:0] a, input logic u);
        @(posedge core_clk);
        llSet <= 1'b1;
        link_address <= a;
        llUncached <= u;
        @(posedge core_clk);
        llSet <= 1'b0;
        link_address <= ~a;
    endtask
    task automatic ev(input int e, input logic [31:0] a);
        @(posedge core_clk);
        {snoopStore, eretExec, excTaken, ucStore} <= 4'h8 >> e;
        snoopAddr <= a;
        ucAddr <= a;
        @(posedge core_clk);
        {snoopStore, eretExec, excTaken, ucStore} <= 4'h0;
        snoopAddr <= ~a;
        ucAddr <= ~a;
    endtask
    task automatic sc(input logic [31:0] i, bv, sv, hv);
        int n;
        n = 0;
        monSeen = 1'b0;
        vaSeen = 'x;
        umSeen = 1'bx;
        do begin
            @(posedge core_clk);
            n++;
        end while (issueReady !== 1'b1 && n < 50);
        issueValid <= 1'b1;
        instr <= i;
        baseVal <= bv;
        srcVal <= sv;
        hiVal <= hv;
        @(posedge core_clk);
        issueValid <= 1'b0;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
            if (xlReq === 1'b1) begin
                vaSeen = xlVaddr;
                umSeen = xlUserMap;
            end
            if (monReq.valid === 1'b1) begin
                monSeen = 1'b1;
                mr = monReq;
            end
        end while (result.valid !== 1'b1 && n < 200);
        if (result.valid !== 1'b1) begin
            n_fail++;
            $display("unexpected at %0t: result missing", $time);
        end
        rs = result;
        lvSeen = linkValid;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        #100000;
        $display("unexpected at %0t: watchdog expired", $time);
        n_fail++;
        wrap_up();
    end
    initial begin
        {rst_n, psel, penable, pwrite, issueValid, llSet, llUncached} = '0;
        {snoopStore, eretExec, excTaken, ucStore, slow, uncIn} = '0;
        {paddr, pwdata, instr, baseVal, srcVal, hiVal} = '0;
        {link_address, snoopAddr, ucAddr} = '0;
        {cpuUsable, passIn} = 2'h3;
        excIn = scu_pkg::EXC_NONE;
        n_fail = 0;
        check_count = 0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        apb(1'b0, `SCU_OFF_CFG, 32'h0);
        chk(rd, {29'h0, `SCU_CFG_RST}, "cfg reset");
        apb(1'b0, `SCU_OFF_LADDR, 32'h0);
        d1 = rd;
        apb(1'b1, `SCU_OFF_LADDR, ~d1);
        chk(er, 1'b0, "read-only write");
        apb(1'b0, `SCU_OFF_LADDR, 32'h0);
        chk({er, rd}, {1'b0, d1}, "link address read-only");
        apb(1'b1, 12'h0FC, 32'hFFFFFFFF);
        chk(er, 1'b1, "unmapped access");
        $display("test registers finished");
        for (int i = 0; i < 40; i++) begin
            k = rnd() % 7;
            d1 = rnd();
            va = {d1[31:3], 3'h0};
            slow <= d1[0];
            pa = (k == 1 || k == 5);
            ok = (k <= 1);
            if (k != 6) ll(k == 5 ? va ^ 32'h100 : va, 1'b0);
            if (k >= 2 && k <= 4) ev(k - 2, va ^ 32'h4);
            d1 = rnd();
            o = d1[8:0];
            s = rnd();
            h = rnd();
            ins = pa ? encP(d1[13:9], d1[18:14], d1[23:19])
                : encU(d1[13:9], d1[18:14], o);
            n0 = FAR.wq.size();
            sc(ins, pa ? va : va - {{23{o[8]}}, o}, s, h);
            chk({rs.data, rs.exc}, {31'h0, ok, 3'h0}, "result");
            chk(rs.idx, d1[13:9], "result index");
            chk(vaSeen, va, "effective address");
            chk(umSeen, !pa, "user mapping");
            chk(lvSeen, 1'b0, "link after store");
            chk(FAR.wq.size() - n0, ok ? 1 + pa : 0, "write count");
            if (ok) chk({FAR.wq[n0].addr, FAR.wq[n0].data}, {va, s}, "word");
            if (ok && pa) chk({FAR.wq[n0 + 1].addr, FAR.wq[n0 + 1].data,
                FAR.wq[n0].lock, FAR.wq[n0 + 1].lock}, {va + 32'h4, h, 2'h2},
                "high word");
        end
        $display("test random sequences finished");
        slow <= 1'b0;
        va = 32'h00001000;
        ll(va, 1'b0);
        apb(1'b0, `SCU_OFF_STAT, 32'h0);
        chk(rd[0], 1'b1, "status link");
        apb(1'b0, `SCU_OFF_LADDR, 32'h0);
        chk(rd, va, "link address");
        sc(encU(5'h3, 5'h4, 9'h000), va + 32'h2, 32'h0, 32'h0);
        chk({rs.exc, lvSeen}, {scu_pkg::EXC_ADDR, 1'b0}, "misaligned");
        sc(encP(5'h3, 5'h4, 5'h5), va + 32'h4, 32'h0, 32'h0);
        chk(rs.exc, scu_pkg::EXC_ADDR, "misaligned pair");
        cpuUsable <= 1'b0;
        sc(encU(5'h3, 5'h4, 9'h000), va, 32'h0, 32'h0);
        chk(rs.exc, scu_pkg::EXC_CPU, "unusable");
        cpuUsable <= 1'b1;
        sc({`SCU_MAJOR, 10'h0, 4'hB, 12'h0}, va, 32'h0, 32'h0);
        chk(rs.exc, scu_pkg::EXC_RI, "unknown subcode");
        for (int e = 4; e < 8; e++) begin
            excIn <= scu_pkg::scu_exc_t'(e);
            n0 = FAR.wq.size();
            ll(va, 1'b0);
            sc(encU(5'h3, 5'h4, 9'h000), va, 32'h0, 32'h0);
            chk(rs.exc, e, "translation fault");
            chk(FAR.wq.size(), n0, "no write on fault");
        end
        excIn <= scu_pkg::EXC_NONE;
        apb(1'b1, `SCU_OFF_CFG, 32'h0);
        sc(encU(5'h3, 5'h4, 9'h000), va, 32'h0, 32'h0);
        chk(rs.exc, scu_pkg::EXC_RI, "user form disabled");
        apb(1'b1, `SCU_OFF_CFG, (32'h1 << `SCU_CFG_PAIRABS) | 32'h1);
        sc(encP(5'h3, 5'h4, 5'h5), va, 32'h0, 32'h0);
        chk(rs.exc, scu_pkg::EXC_RI, "paired absent");
        $display("test faults finished");
        uncIn <= 1'b1;
        apb(1'b1, `SCU_OFF_CFG, 32'h1);
        ll(va, 1'b1);
        sc(encP(5'h3, 5'h4, 5'h5), va, 32'h11, 32'h22);
        chk({rs.data, monSeen}, 33'h0, "uncached disabled");
        apb(1'b1, `SCU_OFF_CFG, (32'h1 << `SCU_CFG_UCLINK) | 32'h1);
        for (int p = 0; p < 3; p++) begin
            passIn <= p[0];
            ll(va, 1'b1);
            if (p == 2) ev(3, va);
            s = rnd();
            h = rnd();
            sc(encP(5'h3, 5'h4, 5'h5), va, s, h);
            chk(rs.data, p == 1, "monitor verdict");
            chk(monSeen, p < 2, "monitor asked");
            if (p < 2) chk({mr.addr, mr.data, mr.paired}, {va, h, s, 1'b1},
                "monitor request");
        end
        $display("test uncached finished");
        wrap_up();
    end
endmodule
